// ### rtl/stop_pkg.sv
package stop_pkg;

   // Register byte offsets on the bus
   localparam logic [3:0] OFS_STOP_HIGH = 4'h0;
   localparam logic [3:0] OFS_STOP_LOW  = 4'h4;
   localparam logic [3:0] OFS_STANDBY   = 4'h8;
   localparam logic [3:0] OFS_STATUS    = 4'hC;

   // Values after reset
   localparam logic [7:0] STOP_HIGH_RESET = 8'h0F;
   localparam logic [7:0] STOP_LOW_RESET  = 8'hFF;
   localparam logic [3:0] SELECT_RESET    = 4'hF;

   // Field positions inside the high byte
   localparam int ALL_STOP_EN_BIT = 7;
   localparam int DMA_BIT         = 5;
   localparam int TRANSFER_BIT    = 4;
   localparam int PULSE_TIMER_BIT = 3;
   localparam int PULSE_GEN_BIT   = 2;
   localparam int DAC_HI_BIT      = 0;
   // Field positions inside the low byte
   localparam int ADC_BIT         = 6;
   localparam int SERIAL0_BIT     = 1;
   localparam int BYTE_TIMER_BIT  = 0;

   // Peripherals that must sit in module stop, over the 16-bit pair
   localparam logic [15:0] ALL_STOP_MASK    = 16'h3D7F;
   localparam logic [15:0] EXCEPT_TIMER_MASK = 16'h3D7E;

   // Standby wait counts in states (one state is one clock)
   localparam int unsigned WAIT_64    = 64;
   localparam int unsigned WAIT_512   = 512;
   localparam int unsigned WAIT_1024  = 1024;
   localparam int unsigned WAIT_2048  = 2048;
   localparam int unsigned WAIT_4096  = 4096;
   localparam int unsigned WAIT_16K   = 16384;
   localparam int unsigned WAIT_32K   = 32768;
   localparam int unsigned WAIT_64K   = 65536;
   localparam int unsigned WAIT_128K  = 131072;
   localparam int unsigned WAIT_256K  = 262144;
   localparam int unsigned WAIT_512K  = 524288;
   localparam int          WAIT_WIDTH = 20;

   // Power control states
   typedef enum logic [3:0] {
      ST_RUN     = 4'b0001,
      ST_ALLSTOP = 4'b0010,
      ST_WAIT    = 4'b0100,
      ST_RELEASE = 4'b1000
   } power_state_t;

   // Clock gate per peripheral, 1 means held in module stop
   typedef struct packed {
      logic       dma;
      logic       transfer_ctrl;
      logic       pulse_timer;
      logic       pulse_gen;
      logic       dac_hi;
      logic       adc;
      logic [4:0] serial;
      logic       byte_timer;
   } periph_gates_t;

endpackage : stop_pkg

// ### rtl/standby_wait_counter.sv
`timescale 1ns/10ps
module standby_wait_counter #(
   parameter int WIDTH = 20
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Control
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] target,
   // Result
   output logic                  busy,
   output logic                  done
);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic [WIDTH-1:0] limit;
   logic [WIDTH-1:0] next_limit;
   logic             next_busy;
   logic             next_done;

   // Counts states after start and pulses done on the last one
   always_comb begin
      next_count = count;
      next_limit = limit;
      next_busy  = busy;
      next_done  = 1'b0;
      if (start) begin
         next_count = WIDTH'(1);
         next_limit = target;
         next_busy  = 1'b1;
      end else if (busy) begin
         if (count >= limit) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_count = count + WIDTH'(1);
         end
      end
   end

   // Registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         count <= '0;
         limit <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         count <= next_count;
         limit <= next_limit;
         busy  <= next_busy;
         done  <= next_done;
      end
   end

endmodule : standby_wait_counter

// ### rtl/module_stop_and_standby_wait.sv
`timescale 1ns/10ps
module module_stop_and_standby_wait #(
   parameter int unsigned WAIT_16K  = stop_pkg::WAIT_16K,
   parameter int unsigned WAIT_32K  = stop_pkg::WAIT_32K,
   parameter int unsigned WAIT_64K  = stop_pkg::WAIT_64K,
   parameter int unsigned WAIT_128K = stop_pkg::WAIT_128K,
   parameter int unsigned WAIT_256K = stop_pkg::WAIT_256K,
   parameter int unsigned WAIT_512K = stop_pkg::WAIT_512K
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    resetn,
   // Avalon-MM slave
   input  wire logic [3:0]              avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   output logic [31:0]                  avs_readdata,
   output logic                         avs_waitrequest,
   // CPU and standby sequencer
   input  wire logic                    sleep_exec,
   input  wire logic                    standby_active,
   input  wire logic                    wake_irq,
   // Clock control outputs
   output stop_pkg::periph_gates_t      periph_gates,
   output logic                         all_clocks_stop,
   output logic                         clock_release
);

   typedef logic [stop_pkg::WAIT_WIDTH-1:0] wait_t;

   // Maps the standby wait selector to a count of states
   function automatic wait_t wait_states(input logic [3:0] sel);
      case (sel)
         4'h5:    wait_states = wait_t'(stop_pkg::WAIT_64);
         4'h6:    wait_states = wait_t'(stop_pkg::WAIT_512);
         4'h7:    wait_states = wait_t'(stop_pkg::WAIT_1024);
         4'h8:    wait_states = wait_t'(stop_pkg::WAIT_2048);
         4'h9:    wait_states = wait_t'(stop_pkg::WAIT_4096);
         4'hA:    wait_states = wait_t'(WAIT_16K);
         4'hB:    wait_states = wait_t'(WAIT_32K);
         4'hC:    wait_states = wait_t'(WAIT_64K);
         4'hD:    wait_states = wait_t'(WAIT_128K);
         4'hE:    wait_states = wait_t'(WAIT_256K);
         4'hF:    wait_states = wait_t'(WAIT_512K);
         default: wait_states = wait_t'(WAIT_512K); // Prohibited codes
      endcase
   endfunction : wait_states

   // Register state
   logic [7:0]             stop_high;
   logic [7:0]             stop_low;
   logic [3:0]             wait_select;
   logic [7:0]             next_stop_high;
   logic [7:0]             next_stop_low;
   logic [3:0]             next_wait_select;
   logic [31:0]            next_readdata;
   logic                   next_waitrequest;
   logic [15:0]            stop_pair;
   logic                   bus_req;
   logic                   bus_take;

   // Power control state
   stop_pkg::power_state_t state;
   stop_pkg::power_state_t next_state;
   logic                   wake_meta;
   logic                   wake_sync;
   logic                   wake_prev;
   logic                   wake_rise;
   logic                   cnt_start;
   logic                   cnt_busy;
   logic                   cnt_done;

   assign stop_pair = {stop_high, stop_low};
   assign bus_req   = avs_read | avs_write;
   assign bus_take  = bus_req & ~avs_waitrequest;
   assign wake_rise = wake_sync & ~wake_prev;

   // Register writes land at the edge that ends the transfer, one edge after the wait state ends
   always_comb begin
      next_stop_high   = stop_high;
      next_stop_low    = stop_low;
      next_wait_select = wait_select;
      if (bus_take && avs_write) begin
         case (avs_address)
            stop_pkg::OFS_STOP_HIGH:
               next_stop_high = avs_writedata[7:0];
            stop_pkg::OFS_STOP_LOW:
               next_stop_low = avs_writedata[7:0];
            stop_pkg::OFS_STANDBY:
               next_wait_select = avs_writedata[3:0];
            default: ;
         endcase
      end
   end

   // One wait cycle per access, read data loaded with the release
   always_comb begin
      next_waitrequest = ~(bus_req & avs_waitrequest);
      next_readdata    = avs_readdata;
      if (bus_req && avs_waitrequest) begin
         case (avs_address)
            stop_pkg::OFS_STOP_HIGH: next_readdata = {24'h0, stop_high};
            stop_pkg::OFS_STOP_LOW:  next_readdata = {24'h0, stop_low};
            stop_pkg::OFS_STANDBY:   next_readdata = {28'h0, wait_select};
            stop_pkg::OFS_STATUS:
               next_readdata = {28'h0, state};
            default:                 next_readdata = 32'h0;
         endcase
      end
   end

   // Register file and bus answer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stop_high       <= stop_pkg::STOP_HIGH_RESET;
         stop_low        <= stop_pkg::STOP_LOW_RESET;
         wait_select     <= stop_pkg::SELECT_RESET;
         avs_readdata    <= 32'h0;
         avs_waitrequest <= 1'b1;
      end else begin
         stop_high       <= next_stop_high;
         stop_low        <= next_stop_low;
         wait_select     <= next_wait_select;
         avs_readdata    <= next_readdata;
         avs_waitrequest <= next_waitrequest;
      end
   end

   // Peripheral gates come straight from the register bits
   assign periph_gates.dma =
      stop_high[stop_pkg::DMA_BIT];
   assign periph_gates.transfer_ctrl =
      stop_high[stop_pkg::TRANSFER_BIT];
   assign periph_gates.pulse_timer =
      stop_high[stop_pkg::PULSE_TIMER_BIT];
   assign periph_gates.pulse_gen =
      stop_high[stop_pkg::PULSE_GEN_BIT];
   assign periph_gates.dac_hi =
      stop_high[stop_pkg::DAC_HI_BIT];
   assign periph_gates.adc =
      stop_low[stop_pkg::ADC_BIT];
   assign periph_gates.byte_timer =
      stop_low[stop_pkg::BYTE_TIMER_BIT];

   // Serial channels 0..4 on low bits 1..5
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_serial
         assign periph_gates.serial[g] =
            stop_low[stop_pkg::SERIAL0_BIT + g];
      end
   endgenerate

   // Wake interrupt pin passes two flip-flops before use
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
         wake_prev <= 1'b0;
      end else begin
         wake_meta <= wake_irq;
         wake_sync <= wake_meta;
         wake_prev <= wake_sync;
      end
   end

   // All-stop entry on sleep, wake wait after standby
   always_comb begin
      next_state = state;
      cnt_start  = 1'b0;
      case (state)
         stop_pkg::ST_RUN: begin
            if (standby_active && wake_rise) begin
               next_state = stop_pkg::ST_WAIT;
               cnt_start  = 1'b1;
            end else if (sleep_exec && stop_high[stop_pkg::ALL_STOP_EN_BIT] &&
                         (((stop_pair & stop_pkg::ALL_STOP_MASK) ==
                           stop_pkg::ALL_STOP_MASK) ||
                          ((stop_pair & stop_pkg::EXCEPT_TIMER_MASK) ==
                           stop_pkg::EXCEPT_TIMER_MASK))) begin
               next_state = stop_pkg::ST_ALLSTOP;
            end
         end
         stop_pkg::ST_ALLSTOP: begin
            if (wake_rise) begin
               next_state = stop_pkg::ST_RUN;
            end
         end
         stop_pkg::ST_WAIT: begin
            if (cnt_done) begin
               next_state = stop_pkg::ST_RELEASE;
            end
         end
         stop_pkg::ST_RELEASE: next_state = stop_pkg::ST_RUN;
         default:              next_state = stop_pkg::ST_RUN;
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= stop_pkg::ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   assign all_clocks_stop = state[1];
   assign clock_release   = state[3];

   // Counts the selected states before clocks are released
   standby_wait_counter #(
      .WIDTH (stop_pkg::WAIT_WIDTH)
   ) u_wait (
      .clk    (clk),
      .resetn (resetn),
      .start  (cnt_start),
      .target (wait_states(wait_select)),
      .busy   (cnt_busy),
      .done   (cnt_done)
   );

   // Checking helpers: states spent waiting and the count aimed at
   wait_t wait_seen;
   wait_t wait_goal;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wait_seen <= '0;
         wait_goal <= '0;
      end else if (cnt_start) begin
         wait_seen <= '0;
         wait_goal <= wait_states(wait_select);
      end else if (state == stop_pkg::ST_WAIT) begin
         wait_seen <= wait_seen + wait_t'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   wait_length_a: assert property (
      (state == stop_pkg::ST_WAIT) && cnt_done |-> wait_seen == wait_goal)
      else $error("wake wait length differs from selected count");

   short_codes_a: assert property (
      cnt_start && wait_select == 4'h6 |-> ##1 wait_goal == wait_t'(512))
      else $error("code 0110 did not select 512 states");

   long_codes_a: assert property (
      cnt_start && wait_select == 4'hA |-> ##1 wait_goal == wait_t'(WAIT_16K))
      else $error("code 1010 did not select the 16384 state wait");

   no_early_release_a: assert property (
      clock_release |-> $past(cnt_done))
      else $error("clock released before the wait ended");

   // The counter stays busy, or just done, for the whole wait
   wait_busy_a: assert property (
      state == stop_pkg::ST_WAIT |-> cnt_busy || cnt_done)
      else $error("wait state left the counter idle");

   release_after_done_a: assert property (
      (state == stop_pkg::ST_WAIT) && cnt_done |=> clock_release ##1
      !clock_release)
      else $error("release did not follow the count by one cycle");

   write_gate_a: assert property (
      bus_take && avs_write && avs_address == stop_pkg::OFS_STOP_LOW |=>
      periph_gates.adc == $past(avs_writedata[6]) &&
      periph_gates.byte_timer == $past(avs_writedata[0]))
      else $error("module stop write did not reach the gates");

   enable_needed_a: assert property (
      $rose(all_clocks_stop) |-> $past(stop_high[stop_pkg::ALL_STOP_EN_BIT]))
      else $error("all clocks stopped without the enable");

   allstop_entry_a: assert property (
      state == stop_pkg::ST_RUN && sleep_exec && !standby_active &&
      stop_high[stop_pkg::ALL_STOP_EN_BIT] &&
      (stop_pair & stop_pkg::ALL_STOP_MASK) == stop_pkg::ALL_STOP_MASK
      |=> all_clocks_stop)
      else $error("sleep with all stopped did not stop all clocks");

   timer_exempt_a: assert property (
      $rose(all_clocks_stop) |->
      ($past(stop_pair) & stop_pkg::EXCEPT_TIMER_MASK) ==
      stop_pkg::EXCEPT_TIMER_MASK)
      else $error("all clocks stopped with a peripheral running");

   one_cycle_wait_a: assert property (
      bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not given after one wait cycle");

   allstop_cover: cover property ($rose(all_clocks_stop));
   release_cover: cover property (clock_release);
   timer_run_cover: cover property (
      $rose(all_clocks_stop) && !$past(stop_low[0]));
   read_cover: cover property (avs_read && !avs_waitrequest);

endmodule : module_stop_and_standby_wait

// ### testbench/module_stop_and_standby_wait_tb_top.sv
`timescale 1ns/10ps
module module_stop_and_standby_wait_tb_top;
   // Shortened long waits keep the run brief
   localparam int unsigned W16  = 20;
   localparam int unsigned W32  = 24;
   localparam int unsigned W64  = 28;
   localparam int unsigned W128 = 32;
   localparam int unsigned W256 = 36;
   localparam int unsigned W512 = 40;
   localparam int          LIMIT = 30000;

   // Stimulus and observed outputs
   logic                    clk             = 1'h0;
   logic                    resetn          = 1'h0;
   logic [3:0]              avs_address     = 4'h0;
   logic                    avs_read        = 1'h0;
   logic                    avs_write       = 1'h0;
   logic [31:0]             avs_writedata   = 32'h00000000;
   logic                    sleep_exec      = 1'h0;
   logic                    standby_active  = 1'h0;
   logic                    wake_irq        = 1'h0;
   logic [31:0]             avs_readdata;
   logic                    avs_waitrequest;
   stop_pkg::periph_gates_t periph_gates;
   logic                    all_clocks_stop;
   logic                    clock_release;
   int                      err_total       = 0;
   int                      checks_done     = 0;
   int                      cycles          = 0;

   // Clock at 250 MHz
   always #2 clk = ~clk;

   module_stop_and_standby_wait #(
      .WAIT_16K(W16), .WAIT_32K(W32), .WAIT_64K(W64),
      .WAIT_128K(W128), .WAIT_256K(W256), .WAIT_512K(W512)
   ) DUT (
      .clk(clk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sleep_exec(sleep_exec), .standby_active(standby_active),
      .wake_irq(wake_irq), .periph_gates(periph_gates),
      .all_clocks_stop(all_clocks_stop), .clock_release(clock_release)
   );

   // Closing report
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict

   // Cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= {24'h000000, d};
      avs_write     <= wr;
      avs_read      <= ~wr;
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_read  <= 1'h0;
      avs_write <= 1'h0;
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask : wr

   task automatic rd_check(input string what, input logic [3:0] a,
                           input logic [31:0] exp);
      logic [31:0] q;
      bus(1'h0, a, 8'h00, q);
      check(what, exp, q);
   endtask : rd_check

   // Expected gate vector from the two stop bytes
   function automatic logic [31:0] gates_of(logic [7:0] hi, logic [7:0] lo);
      return {20'h00000, hi[5], hi[4], hi[3], hi[2], hi[0], lo[6:0]};
   endfunction : gates_of

   // Expected standby wait per selector code
   function automatic int wait_of(logic [3:0] c);
      case (c)
         4'h5: return 64;
         4'h6: return 512;
         4'h7: return 1024;
         4'h8: return 2048;
         4'h9: return 4096;
         4'hA: return W16;
         4'hB: return W32;
         4'hC: return W64;
         4'hD: return W128;
         4'hE: return W256;
         default: return W512;
      endcase
   endfunction : wait_of

   task automatic do_reset();
      @(posedge clk);
      resetn <= 1'h0;
      repeat (20) @(posedge clk);
      resetn <= 1'h1;
   endtask : do_reset

   task automatic test_defaults();
      #1;
      check("gates", gates_of(8'h0F, 8'hFF), {20'h00000, periph_gates});
      check("all stop", 32'h00000000, {31'h0, all_clocks_stop});
      rd_check("high", stop_pkg::OFS_STOP_HIGH, 32'h0000000F);
      rd_check("low", stop_pkg::OFS_STOP_LOW, 32'h000000FF);
      rd_check("select", stop_pkg::OFS_STANDBY, 32'h0000000F);
      rd_check("status", stop_pkg::OFS_STATUS, 32'h00000001);
      $display("test defaults done");
   endtask : test_defaults

   task automatic test_gates();
      logic [7:0] hi_p [4] = '{8'h00, 8'h3D, 8'h20, 8'h14};
      logic [7:0] lo_p [4] = '{8'h00, 8'h7F, 8'h01, 8'h2A};
      for (int i = 0; i < 4; i++) begin
         wr(stop_pkg::OFS_STOP_HIGH, hi_p[i]);
         wr(stop_pkg::OFS_STOP_LOW, lo_p[i]);
         rd_check("high rb", stop_pkg::OFS_STOP_HIGH, {24'h000000, hi_p[i]});
         check("gates", gates_of(hi_p[i], lo_p[i]), {20'h00000, periph_gates});
      end
      // Unmapped and read-only places leave state alone
      wr(4'h2, 8'hFF);
      wr(stop_pkg::OFS_STATUS, 8'hFF);
      rd_check("unmapped", 4'h2, 32'h00000000);
      rd_check("status ro", stop_pkg::OFS_STATUS, 32'h00000001);
      rd_check("high kept", stop_pkg::OFS_STOP_HIGH, 32'h00000014);
      $display("test gates done");
   endtask : test_gates

   // Sleep with given stop bytes, then leave through a wake edge when all stop is expected
   task automatic sleep_try(input logic [7:0] hi, input logic [7:0] lo,
                            input logic exp);
      wr(stop_pkg::OFS_STOP_HIGH, hi);
      wr(stop_pkg::OFS_STOP_LOW, lo);
      @(posedge clk);
      sleep_exec <= 1'h1;
      @(posedge clk);
      sleep_exec <= 1'h0;
      #1 check("all stop", {31'h0, exp}, {31'h0, all_clocks_stop});
      if (exp) begin
         rd_check("status stop", stop_pkg::OFS_STATUS, 32'h00000002);
         @(posedge clk);
         wake_irq <= 1'h1;
         repeat (3) @(posedge clk);
         #1 check("wake exit", 32'h00000000, {31'h0, all_clocks_stop});
         @(posedge clk);
         wake_irq <= 1'h0;
         repeat (4) @(posedge clk);
      end
   endtask : sleep_try

   task automatic test_all_stop();
      sleep_try(8'hBD, 8'h7F, 1'h1);
      sleep_try(8'hBD, 8'h7E, 1'h1);
      sleep_try(8'h3D, 8'h7F, 1'h0);
      sleep_try(8'hBD, 8'h7C, 1'h0);
      sleep_try(8'h9D, 8'h7F, 1'h0);
      $display("test all stop done");
   endtask : test_all_stop

   // Cycles from wake edge to release for one selector code
   task automatic measure(input logic [3:0] code, output int lat);
      wr(stop_pkg::OFS_STANDBY, {4'h0, code});
      @(posedge clk);
      standby_active <= 1'h1;
      @(posedge clk);
      wake_irq <= 1'h1;
      lat = 0;
      do begin
         @(posedge clk);
         lat++;
      end while (clock_release !== 1'h1);
      standby_active <= 1'h0;
      wake_irq       <= 1'h0;
      @(posedge clk);
      check("release width", 32'h00000000, {31'h0, clock_release});
      repeat (4) @(posedge clk);
   endtask : measure

   task automatic test_wait();
      logic [3:0] codes [11] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB,
                                 4'hC, 4'hD, 4'hE, 4'hF, 4'h5};
      int base;
      int lat;
      bit seen;
      measure(4'h5, base);
      check("base wait", 32'h00000001, {31'h0, base > 64});
      for (int i = 0; i < 11; i++) begin
         measure(codes[i], lat);
         check("wait", wait_of(codes[i]) - 64, lat - base);
      end
      rd_check("status run", stop_pkg::OFS_STATUS, 32'h00000001);
      // A wake outside standby releases nothing
      seen = 1'b0;
      @(posedge clk);
      wake_irq <= 1'h1;
      repeat (20) begin
         @(posedge clk);
         if (clock_release === 1'h1) seen = 1'b1;
      end
      wake_irq <= 1'h0;
      check("no standby", 32'h00000000, {31'h0, seen});
      $display("test wait done");
   endtask : test_wait

   // Main sequence, with a second reset in mid-run
   initial begin
      do_reset();
      test_defaults();
      test_gates();
      test_all_stop();
      test_wait();
      do_reset();
      test_defaults();
      give_verdict();
   end

endmodule : module_stop_and_standby_wait_tb_top
